// ===== core/icl_pkg.sv
// Shared constants and types for the inching level control block.
// Assumes a single 25 MHz clock and a plain register port with 16-bit data.
package icl_pkg;

  // Data and level scaling: level counts in hundredths of a percent
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned ADDR_W    = 8;
  localparam logic [15:0] LEVEL_MIN = 16'h0000;
  localparam logic [15:0] LEVEL_MAX = 16'h2710;

  // Clock and ramp time base; ramp settings count in milliseconds
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned RAMP_TICK_MS = 1;
  localparam logic [31:0] CYC_PER_TICK =
    32'(CLK_HZ / 1000 * RAMP_TICK_MS);

  // Source selection: 8 source kinds of 8 instances each
  localparam int unsigned SRC_KIND_W = 3;
  localparam int unsigned SRC_IDX_W  = 3;
  localparam int unsigned SRC_COUNT  = 64;
  localparam logic [2:0]  SRC_NOT_USED = 3'h0;

  // Register offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_UP_RAMP    = 8'h04;
  localparam logic [7:0] REG_DOWN_RAMP  = 8'h08;
  localparam logic [7:0] REG_UP_NOTCH   = 8'h0c;
  localparam logic [7:0] REG_DOWN_NOTCH = 8'h10;
  localparam logic [7:0] REG_START      = 8'h14;
  localparam logic [7:0] REG_UP_SRC     = 8'h18;
  localparam logic [7:0] REG_DOWN_SRC   = 8'h1c;
  localparam logic [7:0] REG_UP_LO      = 8'h20;
  localparam logic [7:0] REG_UP_HI      = 8'h24;
  localparam logic [7:0] REG_DOWN_LO    = 8'h28;
  localparam logic [7:0] REG_DOWN_HI    = 8'h2c;
  localparam logic [7:0] REG_LEVEL      = 8'h30;
  localparam logic [7:0] REG_STATUS     = 8'h34;

  // Field positions in CTRL and the source selector registers
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_UPM_BIT  = 1;
  localparam int unsigned CTRL_DNM_BIT  = 2;
  localparam int unsigned SRC_IDX_LSB   = 0;
  localparam int unsigned SRC_KIND_LSB  = 4;

  // Values after reset
  localparam logic [15:0] RAMP_RST  = 16'h03e8;
  localparam logic [15:0] NOTCH_RST = 16'h03e8;
  localparam logic [15:0] START_RST = 16'h0000;
  localparam logic [15:0] LO_RST    = 16'h0000;
  localparam logic [15:0] HI_RST    = 16'h8000;

  typedef logic [15:0] icl_word_t;

  // Response per direction
  typedef enum logic {
    ICL_RAMP  = 1'b0,
    ICL_NOTCH = 1'b1
  } icl_resp_e;

  // Motion of the level
  typedef enum logic [2:0] {
    ICL_HOLD = 3'b001,
    ICL_UP   = 3'b010,
    ICL_DOWN = 3'b100
  } icl_motion_e;

  typedef struct packed {
    logic [2:0] kind;
    logic [2:0] index;
  } icl_src_sel_s;

  typedef struct packed {
    icl_resp_e    resp;
    icl_word_t    ramp_ms;
    icl_word_t    notch;
    icl_src_sel_s src;
    icl_word_t    thr_lo;
    icl_word_t    thr_hi;
  } icl_dir_cfg_s;

endpackage

// ===== core/icl_cmd_input.sv
// One command input: source picker plus analog-to-digital hysteresis.
// Source values are synchronous to clk_i; binary kinds are flagged by caller.
`timescale 1ns/10ps
module icl_cmd_input
  import icl_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_b_i,
  // Selection and thresholds
  input  wire icl_src_sel_s                sel_i,
  input  wire icl_word_t                   thr_lo_i,
  input  wire icl_word_t                   thr_hi_i,
  // Candidate sources
  input  wire icl_word_t [SRC_COUNT-1:0]   src_data_i,
  input  wire logic [7:0]                  src_binary_i,
  // Digital command state
  output logic                             cmd_o
);

  icl_word_t value;
  logic      binary;
  logic      cmd_d;

  assign value  = src_data_i[{sel_i.kind, sel_i.index}];
  assign binary = src_binary_i[sel_i.kind];

  always_comb begin
    cmd_d = cmd_o;
    if (sel_i.kind == SRC_NOT_USED) begin
      cmd_d = 1'b0;
    end else if (binary) begin
      cmd_d = (value != 16'h0000);
    end else if (value <= thr_lo_i) begin
      cmd_d = 1'b0;
    end else if (value >= thr_hi_i) begin
      cmd_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_o <= 1'b0;
    end else begin
      cmd_o <= cmd_d;
    end
  end

  // Between the bounds an analog source never moves the command
  hyst_hold_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (sel_i.kind != SRC_NOT_USED && !binary
     && value > thr_lo_i && value < thr_hi_i)
    |=> (cmd_o == $past(cmd_o)))
    else $error("command changed inside hysteresis band");

endmodule

// ===== core/icl_inching.sv
// Inching level control: two command inputs move a 0..100 % level.
// Assumes one 25 MHz clock, source values synchronous to it.
`timescale 1ns/10ps
module icl_inching
  import icl_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_b_i,
  // Register port
  input  wire logic [ADDR_W-1:0]          addr_i,
  input  wire icl_word_t                  wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output icl_word_t                       rdata_o,
  // Command sources
  input  wire icl_word_t [SRC_COUNT-1:0]  src_data_i,
  input  wire logic [7:0]                 src_binary_i,
  // Level and command state
  output icl_word_t                       level_o,
  output logic                            up_cmd_o,
  output logic                            down_cmd_o
);

  logic         enable_q;
  icl_dir_cfg_s up_cfg_q;
  icl_dir_cfg_s dn_cfg_q;
  icl_word_t    start_q;
  icl_word_t    level_q;
  icl_word_t    level_d;
  logic         started_q;
  logic         started_d;
  logic         up_prev_q;
  logic         dn_prev_q;
  logic [31:0]  acc_q;
  logic [31:0]  acc_d;
  icl_motion_e  motion_q;
  icl_motion_e  motion_d;
  logic         up_cmd;
  logic         dn_cmd;
  logic         up_rise;
  logic         dn_rise;
  logic [31:0]  up_limit;
  logic [31:0]  dn_limit;
  logic [31:0]  acc_sum;
  icl_word_t    rdata_d;

  function automatic icl_word_t sat_add(input icl_word_t a,
                                        input icl_word_t b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s > {1'b0, LEVEL_MAX}) ? LEVEL_MAX : s[15:0];
  endfunction

  function automatic icl_word_t sat_sub(input icl_word_t a,
                                        input icl_word_t b);
    return (a > b) ? a - b : LEVEL_MIN;
  endfunction

  // Register writes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      enable_q <= 1'b0;
      up_cfg_q <= '{ICL_RAMP, RAMP_RST, NOTCH_RST, '0, LO_RST, HI_RST};
      dn_cfg_q <= '{ICL_RAMP, RAMP_RST, NOTCH_RST, '0, LO_RST, HI_RST};
      start_q  <= START_RST;
    end else if (wr_i) begin
      unique case (addr_i)
        REG_CTRL: begin
          enable_q      <= wdata_i[CTRL_EN_BIT];
          up_cfg_q.resp <= icl_resp_e'(wdata_i[CTRL_UPM_BIT]);
          dn_cfg_q.resp <= icl_resp_e'(wdata_i[CTRL_DNM_BIT]);
        end
        REG_UP_RAMP:    up_cfg_q.ramp_ms <= wdata_i;
        REG_DOWN_RAMP:  dn_cfg_q.ramp_ms <= wdata_i;
        REG_UP_NOTCH:   up_cfg_q.notch   <= wdata_i;
        REG_DOWN_NOTCH: dn_cfg_q.notch   <= wdata_i;
        REG_START:      start_q <= (wdata_i > LEVEL_MAX) ? LEVEL_MAX : wdata_i;
        REG_UP_SRC: begin
          up_cfg_q.src.kind  <= wdata_i[SRC_KIND_LSB +: SRC_KIND_W];
          up_cfg_q.src.index <= wdata_i[SRC_IDX_LSB +: SRC_IDX_W];
        end
        REG_DOWN_SRC: begin
          dn_cfg_q.src.kind  <= wdata_i[SRC_KIND_LSB +: SRC_KIND_W];
          dn_cfg_q.src.index <= wdata_i[SRC_IDX_LSB +: SRC_IDX_W];
        end
        REG_UP_LO:      up_cfg_q.thr_lo <= wdata_i;
        REG_UP_HI:      up_cfg_q.thr_hi <= wdata_i;
        REG_DOWN_LO:    dn_cfg_q.thr_lo <= wdata_i;
        REG_DOWN_HI:    dn_cfg_q.thr_hi <= wdata_i;
        default: ;
      endcase
    end
  end

  // Register reads; data stand for one cycle only, unmapped reads zero
  always_comb begin
    rdata_d = 16'h0000;
    unique case (addr_i)
      REG_CTRL:       rdata_d = {13'h0000, dn_cfg_q.resp, up_cfg_q.resp,
                                 enable_q};
      REG_UP_RAMP:    rdata_d = up_cfg_q.ramp_ms;
      REG_DOWN_RAMP:  rdata_d = dn_cfg_q.ramp_ms;
      REG_UP_NOTCH:   rdata_d = up_cfg_q.notch;
      REG_DOWN_NOTCH: rdata_d = dn_cfg_q.notch;
      REG_START:      rdata_d = start_q;
      REG_UP_SRC:     rdata_d = {9'h000, up_cfg_q.src.kind, 1'b0,
                                 up_cfg_q.src.index};
      REG_DOWN_SRC:   rdata_d = {9'h000, dn_cfg_q.src.kind, 1'b0,
                                 dn_cfg_q.src.index};
      REG_UP_LO:      rdata_d = up_cfg_q.thr_lo;
      REG_UP_HI:      rdata_d = up_cfg_q.thr_hi;
      REG_DOWN_LO:    rdata_d = dn_cfg_q.thr_lo;
      REG_DOWN_HI:    rdata_d = dn_cfg_q.thr_hi;
      REG_LEVEL:      rdata_d = level_q;
      REG_STATUS:     rdata_d = {10'h000, motion_q, started_q, dn_cmd,
                                 up_cmd};
      default:        rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= rd_i ? rdata_d : 16'h0000;
    end
  end

  // Command inputs, one per direction
  icl_cmd_input u_up_cmd (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .sel_i        (up_cfg_q.src),
    .thr_lo_i     (up_cfg_q.thr_lo),
    .thr_hi_i     (up_cfg_q.thr_hi),
    .src_data_i   (src_data_i),
    .src_binary_i (src_binary_i),
    .cmd_o        (up_cmd)
  );

  icl_cmd_input u_dn_cmd (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .sel_i        (dn_cfg_q.src),
    .thr_lo_i     (dn_cfg_q.thr_lo),
    .thr_hi_i     (dn_cfg_q.thr_hi),
    .src_data_i   (src_data_i),
    .src_binary_i (src_binary_i),
    .cmd_o        (dn_cmd)
  );

  assign up_cmd_o   = up_cmd;
  assign down_cmd_o = dn_cmd;
  assign level_o    = level_q;

  // Edge memory for notch response
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      up_prev_q <= 1'b0;
      dn_prev_q <= 1'b0;
    end else begin
      up_prev_q <= up_cmd;
      dn_prev_q <= dn_cmd;
    end
  end

  assign up_rise = up_cmd && !up_prev_q;
  assign dn_rise = dn_cmd && !dn_prev_q;

  // Exclusive-or decode of the two commands
  always_comb begin
    if (up_cmd && !dn_cmd) begin
      motion_d = ICL_UP;
    end else if (dn_cmd && !up_cmd) begin
      motion_d = ICL_DOWN;
    end else begin
      motion_d = ICL_HOLD;
    end
  end

  // Cycles for a full-span ramp; 16 x 15 bits never overflows 32 bits
  assign up_limit = 32'(up_cfg_q.ramp_ms) * CYC_PER_TICK;
  assign dn_limit = 32'(dn_cfg_q.ramp_ms) * CYC_PER_TICK;
  // Accumulator restarts whenever motion changes, so a ramp is not
  // nudged by fractional progress left from an earlier move.
  assign acc_sum  = ((motion_d == motion_q) ? acc_q : 32'h0000_0000)
                    + 32'(LEVEL_MAX);

  // Level update; fractional steps spread evenly by an accumulator
  always_comb begin
    level_d   = level_q;
    acc_d     = 32'h0000_0000;
    started_d = started_q;
    if (!enable_q) begin
      level_d   = start_q;
      started_d = 1'b0;
    end else if (!started_q && !up_cmd && !dn_cmd) begin
      level_d = start_q;
    end else begin
      started_d = 1'b1;
      unique case (motion_d)
        ICL_UP: begin
          if (up_cfg_q.resp == ICL_NOTCH) begin
            if (up_rise) begin
              level_d = sat_add(level_q, up_cfg_q.notch);
            end
          end else if (up_limit == 32'h0000_0000) begin
            level_d = LEVEL_MAX;
          end else if (acc_sum >= up_limit) begin
            level_d = sat_add(level_q, 16'h0001);
            acc_d   = acc_sum - up_limit;
          end else begin
            acc_d = acc_sum;
          end
        end
        ICL_DOWN: begin
          if (dn_cfg_q.resp == ICL_NOTCH) begin
            if (dn_rise) begin
              level_d = sat_sub(level_q, dn_cfg_q.notch);
            end
          end else if (dn_limit == 32'h0000_0000) begin
            level_d = LEVEL_MIN;
          end else if (acc_sum >= dn_limit) begin
            level_d = sat_sub(level_q, 16'h0001);
            acc_d   = acc_sum - dn_limit;
          end else begin
            acc_d = acc_sum;
          end
        end
        ICL_HOLD: level_d = level_q;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_q   <= START_RST;
      started_q <= 1'b0;
      acc_q     <= 32'h0000_0000;
      motion_q  <= ICL_HOLD;
    end else begin
      level_q   <= level_d;
      started_q <= started_d;
      acc_q     <= acc_d;
      motion_q  <= motion_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence up_only_s;
    enable_q && started_q && up_cmd && !dn_cmd;
  endsequence

  sequence dn_only_s;
    enable_q && started_q && dn_cmd && !up_cmd;
  endsequence

  level_range_a: assert property (
    level_q <= LEVEL_MAX)
    else $error("level out of range");

  hold_equal_a: assert property (
    (enable_q && started_q && up_cmd == dn_cmd)
    |=> (level_q == $past(level_q)))
    else $error("level moved while commands agree");

  ramp_up_a: assert property (
    (up_only_s and (up_cfg_q.resp == ICL_RAMP))
    |=> (level_q >= $past(level_q)))
    else $error("level fell during up ramp");

  ramp_down_a: assert property (
    (dn_only_s and (dn_cfg_q.resp == ICL_RAMP))
    |=> (level_q <= $past(level_q)))
    else $error("level rose during down ramp");

  notch_held_a: assert property (
    (up_only_s and (up_cfg_q.resp == ICL_NOTCH && up_prev_q))
    |=> (level_q == $past(level_q)))
    else $error("level moved while notch input held");

  notch_step_a: assert property (
    (up_only_s and (up_cfg_q.resp == ICL_NOTCH && !up_prev_q))
    |=> (level_q == sat_add($past(level_q), $past(up_cfg_q.notch))))
    else $error("up notch step wrong");

  start_hold_a: assert property (
    (enable_q && !started_q && !up_cmd && !dn_cmd)
    |=> (level_q == $past(start_q)))
    else $error("level left start value before any command");

  ramp_zero_a: assert property (
    (dn_only_s and (dn_cfg_q.resp == ICL_RAMP
                    && dn_cfg_q.ramp_ms == 16'h0000))
    |=> (level_q == LEVEL_MIN))
    else $error("zero-time down ramp did not reach minimum");

endmodule

// ===== verification/icl_src_model.sv
// Behavioural model of the upstream control sources of the inching block.
// Assumes the bench loads one source value at a time, synchronous to clk_i.
`timescale 1ns/10ps
module icl_src_model
  import icl_pkg::*;
#(
  // Kind 2 is analog, every other kind is digital
  parameter logic [7:0] BIN_KINDS = 8'hfb
)
(
  // Clock
  input  wire logic                        clk_i,
  // Load port from the bench
  input  wire logic                        set_i,
  input  wire logic [5:0]                  set_idx_i,
  input  wire icl_word_t                   set_val_i,
  // Source values seen by the block
  output icl_word_t [SRC_COUNT-1:0]        src_data_o,
  output logic [7:0]                       src_binary_o
);
  // One process owns the values; all sources start at zero
  icl_word_t [SRC_COUNT-1:0] data_q = '0;

  assign src_data_o   = data_q;
  assign src_binary_o = BIN_KINDS;

  // Sources update on the clock like real producer blocks would
  always @(posedge clk_i) begin
    if (set_i) begin
      data_q[set_idx_i] <= set_val_i;
    end
  end
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the inching level control block.
// Assumes icl_pkg and the source model are compiled before this file.
`timescale 1ns/10ps
module tb_top
  import icl_pkg::*;
;
  typedef struct packed {
    logic [7:0] addr;
    icl_word_t  wdata;
    icl_word_t  exp;
  } tb_row_s;

  localparam int LIMIT = 40000;

  logic                     clk_i = 1'b0;
  logic                     rst_b_i = 1'b0;
  logic [7:0]               addr_i = '0;
  icl_word_t                wdata_i = '0;
  logic                     wr_i = 1'b0;
  logic                     rd_i = 1'b0;
  icl_word_t                rdata_o;
  icl_word_t [SRC_COUNT-1:0] src_data;
  logic [7:0]               src_binary;
  icl_word_t                level_o;
  logic                     up_cmd_o;
  logic                     down_cmd_o;
  logic                     set_q = 1'b0;
  logic [5:0]               sidx_q = '0;
  icl_word_t                sval_q = '0;
  int                       err_count = 0;
  int                       compares = 0;
  int                       cyc = 0;
  icl_word_t                held;

  tb_row_s rows [12] = '{
    '{REG_UP_RAMP,    16'h0001, 16'h0001},
    '{REG_DOWN_RAMP,  16'h0002, 16'h0002},
    '{REG_UP_NOTCH,   16'h07d0, 16'h07d0},
    '{REG_DOWN_NOTCH, 16'h0bb8, 16'h0bb8},
    '{REG_START,      16'h3000, 16'h2710},
    '{REG_START,      16'h1388, 16'h1388},
    '{REG_UP_SRC,     16'h0010, 16'h0010},
    '{REG_DOWN_SRC,   16'h0011, 16'h0011},
    '{REG_DOWN_LO,    16'h0064, 16'h0064},
    '{REG_DOWN_HI,    16'h00c8, 16'h00c8},
    '{REG_LEVEL,      16'h1234, 16'h1388},
    '{8'h3c,          16'hffff, 16'h0000}
  };

  // Notch pulses: source index and level expected afterwards
  logic [5:0] p_idx [7] = '{6'h08, 6'h08, 6'h08, 6'h09, 6'h09, 6'h09,
                            6'h09};
  icl_word_t  p_exp [7] = '{16'h1b58, 16'h2328, 16'h2710, 16'h1b58,
                            16'h0fa0, 16'h03e8, 16'h0000};
  icl_word_t  a_val [4] = '{16'h0096, 16'h00c8, 16'h0096, 16'h0064};
  logic       a_exp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  icl_src_model model (
    .clk_i        (clk_i),
    .set_i        (set_q),
    .set_idx_i    (sidx_q),
    .set_val_i    (sval_q),
    .src_data_o   (src_data),
    .src_binary_o (src_binary)
  );

  icl_inching uut (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .addr_i       (addr_i),
    .wdata_i      (wdata_i),
    .wr_i         (wr_i),
    .rd_i         (rd_i),
    .rdata_o      (rdata_o),
    .src_data_i   (src_data),
    .src_binary_i (src_binary),
    .level_o      (level_o),
    .up_cmd_o     (up_cmd_o),
    .down_cmd_o   (down_cmd_o)
  );

  always #20 clk_i = ~clk_i;

  task automatic final_report();
    $display("Tests done: %0d compares, %0d errors", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A hang counts as a mismatch
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      $display("ERROR %0t timeout", $time);
      final_report();
    end
  end

  task automatic chk(input icl_word_t got, input icl_word_t exp,
                     input int tol);
    compares++;
    if ($isunknown(got) || got + tol < exp || got > exp + tol) begin
      err_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t command %b want %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input icl_word_t d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input icl_word_t exp);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(rdata_o, exp, 0);
  endtask

  task automatic src(input logic [5:0] i, input icl_word_t v, input int n);
    @(posedge clk_i);
    set_q  <= 1'b1;
    sidx_q <= i;
    sval_q <= v;
    @(posedge clk_i);
    set_q  <= 1'b0;
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd_chk(REG_CTRL, 16'h0000);
    rd_chk(REG_UP_RAMP, RAMP_RST);
    rd_chk(REG_DOWN_NOTCH, NOTCH_RST);
    rd_chk(REG_DOWN_HI, HI_RST);
    chk(level_o, START_RST, 0);
    src(6'h00, 16'h0001, 4);
    chk_bit(up_cmd_o, 1'b0);
    $display("Test reset done");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    $display("Test register table done");
    wr(REG_CTRL, 16'h0007);
    repeat (20) @(posedge clk_i);
    #1;
    chk(level_o, 16'h1388, 0);
    $display("Test start value done");
    foreach (p_idx[i]) begin
      src(p_idx[i], 16'h0001, 20);
      chk(level_o, p_exp[i], 0);
      src(p_idx[i], 16'h0000, 4);
    end
    $display("Test notch done");
    wr(REG_DOWN_SRC, 16'h0020);
    foreach (a_val[i]) begin
      src(6'h10, a_val[i], 3);
      chk_bit(down_cmd_o, a_exp[i]);
    end
    $display("Test hysteresis done");
    wr(REG_CTRL, 16'h0001);
    src(6'h08, 16'h0001, 2500);
    chk(level_o, 16'h03e8, 4);
    repeat (23500) @(posedge clk_i);
    #1;
    chk(level_o, 16'h2710, 0);
    src(6'h08, 16'h0000, 0);
    src(6'h10, 16'h00c8, 5000);
    chk(level_o, 16'h2328, 5);
    src(6'h08, 16'h0001, 3);
    held = level_o;
    repeat (100) @(posedge clk_i);
    #1;
    chk(level_o, held, 0);
    chk_bit(up_cmd_o, 1'b1);
    wr(REG_DOWN_RAMP, 16'h0000);
    src(6'h08, 16'h0000, 3);
    chk(level_o, 16'h0000, 0);
    $display("Test ramp done");
    final_report();
  end
endmodule
